// >>> seepc_ctrl.sv
`timescale 1ns/1ns
module seepc_ctrl
  import seepc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int SCLK_DIVIDE    = SCLK_DIV
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               serial_data_in,
  input  wire logic [1:0]         mii_monitor,
  output seepc_pkg::seepc_link_s  link_o
);
  import seepc_pkg::*;

  initial begin
    // Read bits are taken one serial clock late, behind a three-stage synchroniser
    if (TIMEOUT_CYCLES < 2 || SCLK_DIVIDE < 3) begin
      $error("seepc_ctrl: bad parameters");
    end
  end

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic         command_busy;
  seepc_op_e    opcode_field;
  logic [6:0]   location_field;
  logic         response_timeout_flag;
  logic         address_loaded_flag;
  logic [7:0]   eeprom_data_reg;
  logic [31:0]  station_addr_low;
  logic [15:0]  station_addr_high;
  logic [3:0]   cfg;
  seepc_state_e state;
  logic         loading;
  logic [2:0]   load_idx;
  logic [17:0]  shreg;
  logic [4:0]   bit_cnt;
  logic [7:0]   rx;
  logic         sck;
  logic         cs;
  logic         sdo;
  logic         soe;
  logic         tick;
  logic [15:0]  div_cnt;
  logic [31:0]  tmo_cnt;
  logic [2:0]   din_sync;
  logic         din_f;

  wire acc      = psel & penable & pready;
  wire wr_cmd   = acc & pwrite & (paddr == OFF_CMD);
  wire wr_cfg   = acc & pwrite & (paddr == OFF_CFG);
  wire go_cmd   = wr_cmd & ~command_busy & pwdata[CMD_BUSY_BIT];
  wire soft_rst = wr_cfg & pwdata[CFG_SRST_BIT];
  wire tmo_hit  = (state != ST_IDLE) && (tmo_cnt == 32'(TIMEOUT_CYCLES - 1));
  wire fin      = (state == ST_END) && tick && (bit_cnt != 5'h00);
  wire sig_bad  = loading && (load_idx == 3'h0) && (rx != SIGNATURE);
  wire load_end = loading && (load_idx == MAC_BYTES);
  wire is_long  = loading || opcode_field == SEEPC_READ || opcode_field == SEEPC_WRITE
                  || opcode_field == SEEPC_WRALL;
  wire needs_poll = !loading && opcode_field != SEEPC_READ && opcode_field != SEEPC_LOCK
                    && opcode_field != SEEPC_UNLOCK;

  // ----------------------------------------
  // Frame builder
  // ----------------------------------------
  function automatic logic [17:0] frame(input seepc_op_e op, input logic [6:0] loc,
                                        input logic [7:0] d);
    logic [17:0] f;
    f = 18'h00000;
    case (op)
      SEEPC_READ:   f = {1'b1, 2'b10, loc, 8'h00};
      SEEPC_WRITE:  f = {1'b1, 2'b01, loc, d};
      SEEPC_ERASE:  f = {1'b1, 2'b11, loc, 8'h00};
      SEEPC_ERALL:  f = {1'b1, 2'b00, 7'h40, 8'h00};
      SEEPC_LOCK:   f = {1'b1, 2'b00, 7'h00, 8'h00};
      SEEPC_UNLOCK: f = {1'b1, 2'b00, 7'h60, 8'h00};
      SEEPC_WRALL:  f = {1'b1, 2'b00, 7'h20, d};
      default:      f = {1'b1, 2'b10, loc, 8'h00};
    endcase
    return f;
  endfunction

  // ----------------------------------------
  // Serial clock divider and input sync
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else begin
      tick    <= (div_cnt == 16'(SCLK_DIVIDE - 1));
      div_cnt <= (div_cnt == 16'(SCLK_DIVIDE - 1)) ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  // A change is accepted only once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_sync <= 3'h0;
      din_f    <= 1'b0;
    end else begin
      din_sync <= {din_sync[1:0], serial_data_in};
      if (din_sync[1] == din_sync[2]) begin
        din_f <= din_sync[2];
      end
    end
  end

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_IDLE;
      shreg   <= 18'h00000;
      bit_cnt <= 5'h00;
      rx      <= 8'h00;
      sck     <= 1'b0;
      cs      <= 1'b0;
      sdo     <= 1'b0;
      soe     <= 1'b0;
      tmo_cnt <= 32'h00000000;
    end else if (tmo_hit) begin
      state <= ST_IDLE;
      cs    <= 1'b0;
      sck   <= 1'b0;
      soe   <= 1'b0;
    end else begin
      tmo_cnt <= (state == ST_IDLE) ? 32'h00000000 : tmo_cnt + 32'h00000001;
      case (state)
        ST_IDLE: begin
          if (command_busy && tick && cfg[CFG_EN_BIT]) begin
            shreg   <= loading ? frame(SEEPC_READ, {4'h0, load_idx}, 8'h00)
                               : frame(opcode_field, location_field, eeprom_data_reg);
            bit_cnt <= is_long ? 5'(LEN_LONG) : 5'(LEN_SHORT);
            cs      <= 1'b1;
            soe     <= 1'b1;
            sdo     <= 1'b1;
            state   <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick && !sck) begin
            // A full serial clock after the far side moved the line, so the synchroniser has settled
            sck <= 1'b1;
            rx  <= {rx[6:0], din_f};
          end else if (tick) begin
            sck     <= 1'b0;
            shreg   <= {shreg[16:0], 1'b0};
            sdo     <= shreg[16];
            bit_cnt <= bit_cnt - 5'h01;
            // Read data phase: release the shared pin to the EEPROM
            if (bit_cnt <= 5'd9 && (loading || opcode_field == SEEPC_READ)) begin
              soe <= 1'b0;
            end
            if (bit_cnt == 5'h01) begin
              soe   <= 1'b0;
              cs    <= ~needs_poll;
              state <= needs_poll ? ST_GAP : ST_END;
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            cs      <= 1'b1;
            bit_cnt <= 5'h01;
            state   <= ST_POLL;
          end
        end
        ST_POLL: begin
          // EEPROM holds its data line low until the internal cycle ends;
          // the first tick still sees the released line through the synchroniser
          if (tick) begin
            if (bit_cnt != 5'h00) begin
              bit_cnt <= bit_cnt - 5'h01;
            end else if (din_f) begin
              state <= ST_END;
            end
          end
        end
        ST_END: begin
          // One extra tick catches the last read bit before select drops
          if (tick && bit_cnt == 5'h00) begin
            rx      <= {rx[6:0], din_f};
            bit_cnt <= 5'h01;
          end else if (tick) begin
            cs    <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Command register and load sequencing
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_busy          <= 1'b1;
      loading               <= 1'b1;
      load_idx              <= 3'h0;
      opcode_field          <= SEEPC_READ;
      location_field        <= 7'h00;
      response_timeout_flag <= 1'b0;
      address_loaded_flag   <= 1'b0;
    end else if (soft_rst) begin
      command_busy        <= 1'b1;
      loading             <= 1'b1;
      load_idx            <= 3'h0;
      address_loaded_flag <= 1'b0;
    end else if (tmo_hit) begin
      response_timeout_flag <= 1'b1;
      command_busy          <= 1'b0;
      loading               <= 1'b0;
    end else if (go_cmd) begin
      command_busy          <= 1'b1;
      opcode_field          <= seepc_op_e'(pwdata[CMD_OP_LSB +: 3]);
      location_field        <= pwdata[6:0];
      response_timeout_flag <= 1'b0;
      if (seepc_op_e'(pwdata[CMD_OP_LSB +: 3]) == SEEPC_RELOAD) begin
        loading             <= 1'b1;
        load_idx            <= 3'h0;
        address_loaded_flag <= 1'b0;
      end
    end else if (fin) begin
      if (sig_bad || load_end || !loading) begin
        command_busy <= 1'b0;
        loading      <= 1'b0;
      end else begin
        load_idx <= load_idx + 3'h1;
      end
      if (load_end) begin
        address_loaded_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Data and station address registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_data_reg   <= 8'h00;
      station_addr_low  <= 32'hFFFFFFFF;
      station_addr_high <= 16'hFFFF;
    end else begin
      if (acc && pwrite && !command_busy && paddr == OFF_DATA) begin
        eeprom_data_reg <= pwdata[7:0];
      end
      if (acc && pwrite && paddr == OFF_STATION_ADDR_LOW) begin
        station_addr_low <= pwdata;
      end
      if (acc && pwrite && paddr == OFF_STATION_ADDR_HIGH) begin
        station_addr_high <= pwdata[15:0];
      end
      if (fin && !loading && opcode_field == SEEPC_READ) begin
        eeprom_data_reg <= rx;
      end
      if (fin && loading && load_idx != 3'h0) begin
        case (load_idx)
          3'h1: station_addr_low[7:0]   <= rx;
          3'h2: station_addr_low[15:8]  <= rx;
          3'h3: station_addr_low[23:16] <= rx;
          3'h4: station_addr_low[31:24] <= rx;
          3'h5: station_addr_high[7:0]  <= rx;
          default: station_addr_high[15:8] <= rx;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Configuration and pin multiplexing
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg <= pwdata[3:0];
    end
  end

  // Disabled interface hands the pins to general outputs or monitors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_o <= '0;
    end else if (cfg[CFG_EN_BIT]) begin
      link_o <= '{select: cs, clock: sck, data: sdo, data_oe: soe};
    end else if (cfg[CFG_MON_BIT]) begin
      link_o <= '{select: 1'b0, clock: mii_monitor[1], data: mii_monitor[0], data_oe: 1'b1};
    end else begin
      link_o <= '{select: 1'b0, clock: cfg[CFG_GCLK_BIT], data: cfg[CFG_GDATA_BIT],
                  data_oe: 1'b1};
    end
  end

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && penable && !pready) begin
        if (paddr == OFF_CMD) begin
          prdata <= {command_busy, opcode_field, 18'h00000, response_timeout_flag,
                     address_loaded_flag, 1'b0, location_field};
        end else if (paddr == OFF_DATA) begin
          prdata <= {24'h000000, eeprom_data_reg};
        end else if (paddr == OFF_STATION_ADDR_LOW) begin
          prdata <= station_addr_low;
        end else if (paddr == OFF_STATION_ADDR_HIGH) begin
          prdata <= {16'h0000, station_addr_high};
        end else if (paddr == OFF_CFG) begin
          prdata <= {28'h0000000, cfg};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sig_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
    fin && sig_bad && !soft_rst && !go_cmd |=> !command_busy && !address_loaded_flag
      && $stable(station_addr_low))
    else $error("missing signature did not end load cleanly");

  addr_loaded_a: assert property (@(posedge pclk) disable iff (!presetn)
    fin && load_end && !soft_rst |=> address_loaded_flag && !command_busy)
    else $error("loaded flag not set after six bytes");

  first_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    fin && loading && load_idx == 3'h1 |=> station_addr_low[7:0] == $past(rx))
    else $error("first address byte misplaced");

  read_result_a: assert property (@(posedge pclk) disable iff (!presetn)
    fin && !loading && opcode_field == SEEPC_READ && !soft_rst
      |=> eeprom_data_reg == $past(rx) && !command_busy)
    else $error("read byte not in data register at busy clear");

  frame_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == ST_SHIFT) |-> bit_cnt == (is_long ? 5'd18 : 5'd10))
    else $error("wrong serial clock count");

  start_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == ST_SHIFT) |-> shreg[17] && cs && sdo)
    else $error("frame without start bit");

  timeout_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
    tmo_hit && !soft_rst |=> response_timeout_flag && state == ST_IDLE && !command_busy)
    else $error("timeout did not abort");

  busy_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    go_cmd && !soft_rst |=> command_busy ##1 command_busy)
    else $error("busy did not hold after command start");

  pin_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg[CFG_EN_BIT] ##1 !cfg[CFG_EN_BIT] |-> !link_o.select && link_o.data_oe)
    else $error("pins not released when disabled");

endmodule // seepc_ctrl

// >>> seepc_pkg.sv
package seepc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ      = 10_000_000;
  localparam int TIMEOUT_MS  = 30;
  localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int SCLK_DIV    = 5;
  localparam int LEN_SHORT   = 10;
  localparam int LEN_LONG    = 18;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0] OFF_CMD   = 8'h00;
  localparam logic [7:0] OFF_DATA  = 8'h04;
  localparam logic [7:0] OFF_STATION_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFF_STATION_ADDR_HIGH = 8'h0C;
  localparam logic [7:0] OFF_CFG   = 8'h10;
  localparam int CMD_BUSY_BIT  = 31;
  localparam int CMD_OP_LSB    = 28;
  localparam int CMD_TO_BIT    = 9;
  localparam int CMD_LOAD_BIT  = 8;
  localparam int CFG_EN_BIT    = 0;
  localparam int CFG_MON_BIT   = 1;
  localparam int CFG_GDATA_BIT = 2;
  localparam int CFG_GCLK_BIT  = 3;
  localparam int CFG_SRST_BIT  = 31;
  localparam logic [3:0] CFG_RESET = 4'h1;

  // ----------------------------------------
  // Device constants
  // ----------------------------------------
  localparam logic [7:0] SIGNATURE = 8'hA5;
  localparam logic [2:0] MAC_BYTES = 3'h6;

  typedef enum logic [2:0] {
    SEEPC_READ   = 3'b000,
    SEEPC_LOCK   = 3'b001,
    SEEPC_UNLOCK = 3'b010,
    SEEPC_WRITE  = 3'b011,
    SEEPC_WRALL  = 3'b100,
    SEEPC_ERASE  = 3'b101,
    SEEPC_ERALL  = 3'b110,
    SEEPC_RELOAD = 3'b111
  } seepc_op_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SHIFT = 3'b001,
    ST_GAP   = 3'b010,
    ST_POLL  = 3'b011,
    ST_END   = 3'b100
  } seepc_state_e;

  typedef struct packed {
    logic select;
    logic clock;
    logic data;
    logic data_oe;
  } seepc_link_s;

endpackage

// >>> seepc_eeprom_model.sv
`timescale 1ns/1ns
module seepc_eeprom_model #(
  parameter int BUSY_NS = 20000
) (
  input  seepc_pkg::seepc_link_s link,
  input  wire logic              silent,
  output logic                   line
);
  import seepc_pkg::*;
  logic [7:0]  mem [0:127];
  logic [16:0] sh   = '0;
  logic [7:0]  rbuf = '0;
  logic        wen  = 1'b0;
  logic        drv  = 1'b0;
  logic        oval = 1'b1;
  logic        strt = 1'b0;
  logic        prog = 1'b0;
  logic        stat = 1'b0;
  logic        busy = 1'b0;
  logic        p    = 1'b0;
  int          nb   = 0;
  int          rn   = 0;
  wire         cs   = link.select;
  wire         sck  = link.clock;

  // Released line shows the inverse of the last bit, so stale data never passes
  assign line = drv ? oval : ~oval;

  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
  end

  always @(posedge cs) begin
    nb   = 0;
    strt = 1'b0;
    rn   = 0;
    stat = prog;
    drv  = prog;
    if (prog) oval = !busy && !silent;
  end

  always @(busy or silent) begin
    if (stat) oval = !busy && !silent;
  end

  // ----------------------------------------
  // Command shift, read data out on rising clock
  // ----------------------------------------
  always @(posedge sck) begin
    if (cs) begin
      if (stat) begin
        stat = 1'b0;
        prog = 1'b0;
        drv  = 1'b0;
      end
      if (rn > 0) begin
        oval = rbuf[7];
        rbuf = rbuf << 1;
        rn   = rn - 1;
      end else if (!strt) begin
        strt = link.data;
      end else begin
        sh = {sh[15:0], link.data};
        nb = nb + 1;
        if (nb == 9 && sh[8:7] == 2'b10) begin
          rbuf = mem[sh[6:0]];
          rn   = 8;
          drv  = 1'b1;
          oval = 1'b0;
        end
        if (nb == 9 && sh[8:5] == 4'b0011) wen = 1'b1;
        if (nb == 9 && sh[8:5] == 4'b0000) wen = 1'b0;
      end
    end
  end

  // Programming starts when select drops; a locked part still reports ready
  always @(negedge cs) begin
    drv = 1'b0;
    p   = 1'b0;
    if (strt && nb == 17 && sh[16:15] == 2'b01) begin
      p = 1'b1;
      if (wen) mem[sh[14:8]] = sh[7:0];
    end
    if (strt && nb == 17 && sh[16:13] == 4'b0001) begin
      p = 1'b1;
      if (wen) for (int i = 0; i < 128; i++) mem[i] = sh[7:0];
    end
    if (strt && nb == 9 && sh[8:7] == 2'b11) begin
      p = 1'b1;
      if (wen) mem[sh[6:0]] = 8'hFF;
    end
    if (strt && nb == 9 && sh[8:5] == 4'b0010) begin
      p = 1'b1;
      if (wen) for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
    end
    if (p) prog = 1'b1;
    if (p && wen) begin
      fork
        begin
          busy = 1'b1;
          #(BUSY_NS);
          busy = 1'b0;
        end
      join_none
    end
  end
endmodule  // seepc_eeprom_model

// >>> tb_seepc_ctrl.sv
`timescale 1ns/1ns
module tb_seepc_ctrl;
  import seepc_pkg::*;
  localparam int LIMIT = 60000;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [1:0]  mii     = 2'h0;
  logic        silent  = 1'b0;
  logic        sck_q   = 1'b0;
  logic        cs_q    = 1'b0;
  int          clk_cnt = 0;
  int          fclks   = 0;
  int          cyc     = 0;
  int          n_fail  = 0;
  int          num_checks = 0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        eep_line;
  logic        sdi;
  logic [31:0] v;
  logic        err;
  seepc_link_s link;

  // Controller wins the data pin while it drives it
  assign sdi = link.data_oe ? link.data : eep_line;

  seepc_ctrl #(.TIMEOUT_CYCLES(2000), .SCLK_DIVIDE(4)) u_seepc_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_data_in(sdi), .mii_monitor(mii), .link_o(link));
  seepc_eeprom_model u_seepc_eeprom_model (.link(link), .silent(silent), .line(eep_line));

  always #50 pclk = ~pclk;

  // ----------------------------------------
  // Serial clocks per frame, and hang guard
  // ----------------------------------------
  always @(posedge pclk) begin
    sck_q <= link.clock;
    cs_q  <= link.select;
    if (link.select && !cs_q) clk_cnt <= 0;
    else if (link.select && link.clock && !sck_q) clk_cnt <= clk_cnt + 1;
    if (!link.select && cs_q && clk_cnt != 0) fclks <= clk_cnt;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(OFF_CMD, v);
      n++;
    end while (v[CMD_BUSY_BIT] !== 1'b0 && n < 1000);
    check("busy clear", {31'h0, v[CMD_BUSY_BIT]}, 32'h0);
  endtask

  task automatic run(input logic [2:0] op, input logic [6:0] loc, input int clks);
    wr(OFF_CMD, {1'b1, op, 21'h0, loc});
    wait_idle();
    if (clks != 0) check("serial clocks", 32'(fclks), 32'(clks));
  endtask

  task automatic rdloc(input logic [6:0] loc, input logic [7:0] exp);
    run(SEEPC_READ, loc, 18);
    rd(OFF_DATA, v);
    check("read data", {24'h0, v[7:0]}, {24'h0, exp});
  endtask

  task automatic expect_load(input logic f, input logic [31:0] lo, input logic [15:0] hi);
    rd(OFF_CMD, v);
    check("loaded flag", {31'h0, v[CMD_LOAD_BIT]}, {31'h0, f});
    rd(OFF_STATION_ADDR_LOW, v);
    check("station low", v, lo);
    rd(OFF_STATION_ADDR_HIGH, v);
    check("station high", {16'h0, v[15:0]}, {16'h0, hi});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    #1;
    u_seepc_eeprom_model.mem[0] = SIGNATURE;
    for (int i = 1; i < 7; i++) u_seepc_eeprom_model.mem[i] = 8'(i * 17);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CMD, v);
    check("busy at start", {31'h0, v[CMD_BUSY_BIT]}, 32'h1);
    rd(OFF_STATION_ADDR_LOW, v);
    check("station low at reset", v, 32'hFFFF_FFFF);
    rd(OFF_CFG, v);
    check("config at reset", {28'h0, v[3:0]}, {28'h0, CFG_RESET});
    apb(1'b0, 8'h20, 32'h0, v, err);
    check("unmapped", {err, v[30:0]}, 32'h8000_0000);
    wait_idle();
    expect_load(1'b1, 32'h4433_2211, 16'h6655);
    run(SEEPC_UNLOCK, 7'h00, 10);
    wr(OFF_DATA, 32'h3C);
    run(SEEPC_WRITE, 7'h7F, 18);
    rdloc(7'h7F, 8'h3C);
    run(SEEPC_ERASE, 7'h7F, 10);
    rdloc(7'h7F, 8'hFF);
    wr(OFF_DATA, 32'h96);
    run(SEEPC_WRALL, 7'h00, 18);
    rdloc(7'h05, 8'h96);
    run(SEEPC_LOCK, 7'h00, 10);
    wr(OFF_DATA, 32'h00);
    run(SEEPC_WRITE, 7'h05, 18);
    rdloc(7'h05, 8'h96);
    run(SEEPC_UNLOCK, 7'h00, 10);
    run(SEEPC_ERALL, 7'h00, 10);
    rdloc(7'h40, 8'hFF);
    wr(OFF_DATA, 32'h5A);
    run(SEEPC_WRITE, 7'h00, 18);
    run(SEEPC_RELOAD, 7'h00, 0);
    expect_load(1'b0, 32'h4433_2211, 16'h6655);
    wr(OFF_DATA, {24'h0, SIGNATURE});
    run(SEEPC_WRITE, 7'h00, 18);
    wr(OFF_DATA, 32'h77);
    run(SEEPC_WRITE, 7'h01, 18);
    run(SEEPC_RELOAD, 7'h00, 0);
    expect_load(1'b1, 32'hFFFF_FF77, 16'hFFFF);
    silent <= 1'b1;
    run(SEEPC_WRITE, 7'h02, 18);
    rd(OFF_CMD, v);
    check("timeout flag", {31'h0, v[CMD_TO_BIT]}, 32'h1);
    silent <= 1'b0;
    rdloc(7'h02, 8'h77);
    rd(OFF_CMD, v);
    check("timeout cleared", {31'h0, v[CMD_TO_BIT]}, 32'h0);
    wr(OFF_CFG, 32'h0000_0004);
    repeat (3) @(posedge pclk);
    check("gpio pins", {30'h0, link.clock, link.data}, 32'h1);
    mii <= 2'b10;
    wr(OFF_CFG, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    check("monitor pins", {30'h0, link.clock, link.data}, 32'h2);
    wr(OFF_CFG, 32'h8000_0001);
    wait_idle();
    expect_load(1'b1, 32'hFFFF_7777, 16'hFFFF);
    summarize();
  end
endmodule  // tb_seepc_ctrl
